// ---- core/alu_pkg.sv ----
package alu_pkg;
	// operation selects
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_ADD_CARRY,
		OP_SHIFT_RIGHT,
		OP_CLEAR_BIT,
		OP_SKIP_LOW,
		OP_JUMP
	} op_t;

	localparam int          DATA_W       = 8;
	localparam int          ADDR_W       = 7;
	localparam int          BIT_W        = 3;
	localparam int          PC_W         = 15;
	localparam int          OFFSET_W     = 9;
	localparam int          FILE_DEPTH   = 128;
	localparam int          HALF_BIT     = 4;
	localparam int          FLUSH_CYCLES = 1;
	localparam logic [7:0]  RST_ACC      = 8'h00;
	localparam logic [14:0] RST_PC       = 15'h0000;
	localparam logic        RST_FLAG     = 1'b0;
endpackage : alu_pkg

// ---- core/alu_adder.sv ----
`timescale 1ns/100ps
// 8-bit adder with carry out of bit 3 and bit 7
module alu_adder (
	// operands
	input  wire logic [7:0] i_a,
	input  wire logic [7:0] i_b,
	input  wire logic       i_cin,
	// results
	output logic      [7:0] o_sum,
	output logic            o_carry,
	output logic            o_half
);
	logic [4:0] low;
	logic [8:0] full;

	always_comb begin
		low     = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
		full    = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
		o_sum   = full[7:0];
		o_carry = full[8];
		o_half  = low[4];
	end
endmodule : alu_adder

// ---- core/alu_bit_branch_ops.sv ----
`timescale 1ns/100ps
// How it works
// - add accumulator and file register, route by destination bit
// - add with carry-in too, same routing, carry half-carry zero
// - shift right: bits 7:1 to 6:0, bit 0 to carry
// - shift right keeps bit 7 so sign is preserved
// - clear one selected bit of file register, flags untouched
// - skip when tested bit is zero: flush next, two cycles
// - tested bit one: next instruction runs normally
// - jump: pc becomes pc plus one plus signed 9-bit offset
// - every jump takes two cycles, flushing the fetched instruction
// - pc change or true test costs a second nop cycle
module alu_bit_branch_ops (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// instruction
	input  wire logic        i_valid,
	input  alu_pkg::op_t     i_op,
	input  wire logic [6:0]  i_file_addr,
	input  wire logic [2:0]  i_bit_sel,
	input  wire logic        i_dest,
	input  wire logic [8:0]  i_offset,
	// file register preload
	input  wire logic        i_fill,
	input  wire logic [7:0]  i_fill_data,
	// state
	output logic             o_busy,
	output logic      [7:0]  o_acc,
	output logic      [14:0] o_pc,
	output logic             o_carry,
	output logic             o_half_carry_flag,
	output logic             o_zero,
	// file register read-back
	input  wire logic [6:0]  i_peek_addr,
	output logic      [7:0]  o_peek_data
);
	logic [1:0]  rst_sync_ff;
	logic        rst_n;
	logic [7:0]  file_ff [alu_pkg::FILE_DEPTH];
	logic [7:0]  acc_ff;
	logic [14:0] pc_ff;
	logic        carry_ff;
	logic        half_ff;
	logic        zero_ff;
	logic        flush_ff;
	logic [7:0]  peek_ff;
	logic [7:0]  src;
	logic [7:0]  sum;
	logic        sum_carry;
	logic        sum_half;
	logic [7:0]  nxt_result;
	logic        exec;
	logic        writes;
	logic        take_two;
	logic        carry_in;
	logic        write_file;
	logic        write_acc;
	logic        clear_bit;
	logic        jump_now;
	logic [14:0] jump_target;

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	// both adds share routing and flag updates
	function automatic logic is_add(input alu_pkg::op_t op);
		is_add = (op == alu_pkg::OP_ADD) || (op == alu_pkg::OP_ADD_CARRY);
	endfunction : is_add

	function automatic logic sets_zero(input alu_pkg::op_t op);
		sets_zero = is_add(op) || (op == alu_pkg::OP_SHIFT_RIGHT);
	endfunction : sets_zero

	function automatic logic [14:0] sext_offset(input logic [8:0] k);
		sext_offset = {{(alu_pkg::PC_W - alu_pkg::OFFSET_W){k[8]}}, k};
	endfunction : sext_offset

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign src  = file_ff[i_file_addr];
	// instructions arriving in the flush slot are discarded as a nop
	assign exec = i_valid && !flush_ff;
	assign write_file  = exec && writes && i_dest;
	assign write_acc   = exec && writes && !i_dest;
	assign clear_bit   = exec && (i_op == alu_pkg::OP_CLEAR_BIT);
	assign jump_now    = exec && (i_op == alu_pkg::OP_JUMP);
	assign carry_in    = (i_op == alu_pkg::OP_ADD_CARRY) ? carry_ff : 1'b0;
	assign jump_target = pc_ff + 15'h0001 + sext_offset(i_offset);

	alu_adder u_adder (
		.i_a     (acc_ff),
		.i_b     (src),
		.i_cin   (carry_in),
		.o_sum   (sum),
		.o_carry (sum_carry),
		.o_half  (sum_half)
	);

	always_comb begin
		nxt_result = src;
		writes     = 1'b0;
		case (i_op)
			alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY: begin
				nxt_result = sum;
				writes     = 1'b1;
			end
			alu_pkg::OP_SHIFT_RIGHT: begin
				nxt_result = {src[7], src[7:1]};
				writes     = 1'b1;
			end
			default: begin
				nxt_result = src;
				writes     = 1'b0;
			end
		endcase
	end

	always_comb begin
		case (i_op)
			alu_pkg::OP_SKIP_LOW: take_two = !src[i_bit_sel];
			alu_pkg::OP_JUMP:     take_two = 1'b1;
			default:              take_two = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			flush_ff <= 1'b0;
		end else begin
			flush_ff <= exec && take_two;
		end
	end

	// file array has no reset: contents are undefined until written
	always_ff @(posedge i_clock) begin
		if (write_file) begin
			file_ff[i_file_addr] <= nxt_result;
		end else if (clear_bit) begin
			file_ff[i_file_addr][i_bit_sel] <= 1'b0;
		end else if (i_fill) begin
			// preload only where no instruction writes
			file_ff[i_file_addr] <= i_fill_data;
		end
		peek_ff <= file_ff[i_peek_addr];
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= alu_pkg::RST_ACC;
		end else if (write_acc) begin
			acc_ff <= nxt_result;
		end
	end

	// carry: both adds and the shift
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			carry_ff <= alu_pkg::RST_FLAG;
		end else if (exec) begin
			case (i_op)
				alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY: begin
					carry_ff <= sum_carry;
				end
				alu_pkg::OP_SHIFT_RIGHT: begin
					carry_ff <= src[0];
				end
				default: begin
					carry_ff <= carry_ff;
				end
			endcase
		end
	end

	// half-carry: shift leaves it alone
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			half_ff <= alu_pkg::RST_FLAG;
		end else if (exec && is_add(i_op)) begin
			half_ff <= sum_half;
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			zero_ff <= alu_pkg::RST_FLAG;
		end else if (exec && sets_zero(i_op)) begin
			zero_ff <= is_zero(nxt_result);
		end
	end

	// pc points at the instruction being presented
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pc_ff <= alu_pkg::RST_PC;
		end else if (jump_now) begin
			pc_ff <= jump_target;
		end else if (i_valid) begin
			// flushed slots still advance the pc
			pc_ff <= pc_ff + 15'h0001;
		end
	end

	assign o_busy            = flush_ff;
	assign o_acc             = acc_ff;
	assign o_pc              = pc_ff;
	assign o_carry           = carry_ff;
	assign o_half_carry_flag = half_ff;
	assign o_zero            = zero_ff;
	assign o_peek_data       = peek_ff;
endmodule : alu_bit_branch_ops

// ---- tb/alu_bit_branch_ops_monitor.sv ----
`timescale 1ns/100ps
module alu_bit_branch_ops_monitor (
	// watched ports
	input wire logic	i_clock,
	input wire logic	i_rst_n,
	input wire logic	i_valid,
	input alu_pkg::op_t	i_op,
	input wire logic	i_dest,
	input wire logic [8:0]	i_offset,
	input wire logic	o_busy,
	input wire logic [7:0]	o_acc,
	input wire logic [14:0]	o_pc,
	input wire logic	o_carry,
	input wire logic	o_half_carry_flag,
	input wire logic	o_zero
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire logic go = i_valid && !o_busy;
	sequence jump_s;
		go && i_op == alu_pkg::OP_JUMP;
	endsequence
	jump_busy_a: assert property (jump_s |=> o_busy)
		else $error("no flush");
	jump_pc_a: assert property (jump_s |=> o_pc ==
		$past(o_pc) + 15'h0001 + {{6{$past(i_offset[8])}}, $past(i_offset)})
		else $error("bad target");
	flush_once_a: assert property (o_busy |=> !o_busy)
		else $error("long flush");
	nop_slot_a: assert property (o_busy |=> $stable(o_acc))
		else $error("slot ran");
	plain_step_a: assert property (
		go && i_op < alu_pkg::OP_SKIP_LOW |=> !o_busy) else $error("extra slot");
	quiet_flags_a: assert property (go && i_op >= alu_pkg::OP_CLEAR_BIT
		|=> $stable({o_carry, o_half_carry_flag, o_zero})) else $error("flags");
	shift_half_a: assert property (go && i_op == alu_pkg::OP_SHIFT_RIGHT
		|=> $stable(o_half_carry_flag)) else $error("half changed");
	zero_acc_a: assert property (go && !i_dest && i_op > alu_pkg::OP_NONE
		&& i_op < alu_pkg::OP_CLEAR_BIT |=> o_zero == (o_acc == 8'h00))
		else $error("zero flag");
endmodule : alu_bit_branch_ops_monitor
bind alu_bit_branch_ops alu_bit_branch_ops_monitor i_mon (
	.i_clock           (i_clock),
	.i_rst_n           (i_rst_n),
	.i_valid           (i_valid),
	.i_op              (i_op),
	.i_dest            (i_dest),
	.i_offset          (i_offset),
	.o_busy            (o_busy),
	.o_acc             (o_acc),
	.o_pc              (o_pc),
	.o_carry           (o_carry),
	.o_half_carry_flag (o_half_carry_flag),
	.o_zero            (o_zero)
);

// ---- tb/alu_bit_branch_ops_tb_top.sv ----
`timescale 1ns/100ps
module alu_bit_branch_ops_tb_top;
	logic		i_clock = 1'b0;
	logic		i_rst_n = 1'b0;
	logic		i_valid = 1'b0;
	logic		i_dest = 1'b0;
	alu_pkg::op_t	i_op = alu_pkg::OP_NONE;
	logic [6:0]	i_file_addr = 7'h05;
	logic [6:0]	i_peek_addr = 7'h05;
	logic [2:0]	i_bit_sel = 3'h0;
	logic [8:0]	i_offset = 9'h000;
	logic		i_fill = 1'b0;
	logic [7:0]	i_fill_data = 8'h00;
	logic		o_busy, o_carry, o_half_carry_flag, o_zero;
	logic [7:0]	o_acc, o_peek_data;
	logic [14:0]	o_pc;
	int		err_total = 0;
	int		total_checks = 0;
	always #10 i_clock = ~i_clock;
	alu_bit_branch_ops i_alu_bit_branch_ops (
		.i_clock           (i_clock),
		.i_rst_n           (i_rst_n),
		.i_valid           (i_valid),
		.i_op              (i_op),
		.i_file_addr       (i_file_addr),
		.i_bit_sel         (i_bit_sel),
		.i_dest            (i_dest),
		.i_offset          (i_offset),
		.i_fill            (i_fill),
		.i_fill_data       (i_fill_data),
		.o_busy            (o_busy),
		.o_acc             (o_acc),
		.o_pc              (o_pc),
		.o_carry           (o_carry),
		.o_half_carry_flag (o_half_carry_flag),
		.o_zero            (o_zero),
		.i_peek_addr       (i_peek_addr),
		.o_peek_data       (o_peek_data)
	);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		if (got !== exp)
			err_total++;
	endtask : chk
	task step(input alu_pkg::op_t op, input logic [2:0] b, input logic [8:0] k);
		@(posedge i_clock);
		i_op <= op;
		i_bit_sel <= b;
		i_offset <= k;
		i_fill <= 1'b0;
		i_valid <= 1'b1;
	endtask : step
	// preload lands at the next edge, the one the next step starts on
	task fill(input logic [7:0] d);
		@(posedge i_clock);
		i_valid <= 1'b0;
		i_fill_data <= d;
		i_fill <= 1'b1;
	endtask : fill
	task settle;
		@(posedge i_clock);
		i_fill <= 1'b0;
		i_valid <= 1'b0;
		#1;
	endtask : settle
	task t_jump;
		logic [14:0] p;
		for (int i = 0; i < 2; i++) begin
			step(alu_pkg::OP_JUMP, 3'h0, i ? 9'h100 : 9'h0ff);
			#1 p = o_pc + 15'h0002 + (i ? 15'h7f00 : 15'h00ff);
			// discarded add of the unwritten file would make zero unknown
			step(alu_pkg::OP_ADD, 3'h0, 9'h000);
			#1 chk(o_busy, 32'h1);
			settle;
			chk({o_pc, o_busy, o_zero}, {p, 2'b00});
		end
		$display("jump done");
	endtask : t_jump
	task t_skip;
		for (int b = 0; b < 8; b++)
			step(alu_pkg::OP_CLEAR_BIT, b[2:0], 9'h000);
		step(alu_pkg::OP_SKIP_LOW, 3'h3, 9'h000);
		step(alu_pkg::OP_ADD, 3'h0, 9'h000);
		#1 chk(o_busy, 32'h1);
		settle;
		chk({o_peek_data, o_busy, o_zero}, 32'h0);
		fill(8'h08);
		step(alu_pkg::OP_SKIP_LOW, 3'h3, 9'h000);
		step(alu_pkg::OP_ADD, 3'h0, 9'h000);
		#1 chk(o_busy, 32'h0);
		settle;
		chk(o_acc, 32'h08);
		$display("skip done");
	endtask : t_skip
	task t_add;
		// acc holds 08 from the skip test: 08 + 94 = 9c
		fill(8'h94);
		step(alu_pkg::OP_ADD, 3'h0, 9'h000);
		// 9c + 6f back to file: 0b, carry and half-carry set
		fill(8'h6f);
		step(alu_pkg::OP_ADD, 3'h0, 9'h000);
		i_dest <= 1'b1;
		step(alu_pkg::OP_ADD_CARRY, 3'h0, 9'h000);
		i_dest <= 1'b0;
		#1 chk(o_busy, 32'h0);
		settle;
		chk({o_acc, o_zero, o_carry, o_half_carry_flag}, {8'ha8, 3'b001});
		chk(o_peek_data, 32'h0b);
		fill(8'h58);
		step(alu_pkg::OP_ADD, 3'h0, 9'h000);
		settle;
		chk({o_acc, o_zero, o_carry, o_half_carry_flag}, {8'h00, 3'b111});
		fill(8'h83);
		step(alu_pkg::OP_SHIFT_RIGHT, 3'h0, 9'h000);
		i_dest <= 1'b1;
		step(alu_pkg::OP_SHIFT_RIGHT, 3'h0, 9'h000);
		i_dest <= 1'b0;
		settle;
		chk({o_acc, o_zero, o_carry, o_half_carry_flag}, {8'he0, 3'b011});
		chk(o_peek_data, 32'hc1);
		$display("add done");
	endtask : t_add
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clock);
		#1 chk({o_pc, o_acc, o_busy, o_zero, o_carry}, 32'h0);
		t_jump;
		t_skip;
		t_add;
		print_verdict;
	end
endmodule : alu_bit_branch_ops_tb_top
